// ---- rtl/dmc_pkg.sv ----
// Constants, encodings and timing counts shared by the debug mode control block.
// Assumes a single 200 MHz system clock and an 8N1 character link at a fixed rate.
// What this block does
// - In debug state, CPU instruction fetch halts except when directed instructions execute.
// - System clock keeps running in debug state unless stop mode holds it stopped.
// - Enabled peripherals keep running in debug state except during stop mode.
// - Entering debug state wakes the device from halt mode automatically.
// - Watchdog gets refreshed continuously during debug state when it is enabled.
// - Host writing the debug state request bit to 1 enters debug state.
// - Executing the breakpoint opcode enters debug state.
// - With matching enabled, program counter equal to the countdown register enters debug.
// - With countdown enabled, the countdown register reaching zero enters debug state.
// - Debug link pin low when reset ends puts the device into debug state.
// - Clearing the debug state request bit leaves debug state, resuming fetch.
// - Power-on, brownout or reset pin reset leaves debug state.
// - Debug link pin driven low during stop mode causes a full system reset.
// - Link characters are one start bit, eight data bits LSB first, one stop bit.
package dmc_pkg;

    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned LINK_BAUD_HZ = 115_200;
    localparam int unsigned BIT_CYCLES = CLK_HZ / LINK_BAUD_HZ;
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned BIT_CNT_W = 12;
    localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] HALF_LAST = 12'(HALF_BIT_CYCLES - 1);

    localparam int unsigned DATA_BITS = 8;
    localparam logic [2:0] DATA_LAST = 3'h7;

    // Host command codes
    localparam logic [7:0] CMD_WR_CTRL = 8'h04;
    localparam logic [7:0] CMD_RD_CTRL = 8'h05;
    localparam logic [7:0] CMD_WR_CNT = 8'h30;

    // Control byte layout
    localparam int unsigned CTRL_DBG_BIT = 7;
    localparam int unsigned CTRL_PCM_EN_BIT = 1;
    localparam int unsigned CTRL_CNT_EN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // Synchroniser depth before the reset-exit strap is trusted
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [1:0]
    {
        DMC_RX_IDLE = 2'b00,
        DMC_RX_START = 2'b01,
        DMC_RX_DATA = 2'b10,
        DMC_RX_STOP = 2'b11
    } dmc_rx_e;

    typedef enum logic [1:0]
    {
        DMC_TX_IDLE = 2'b00,
        DMC_TX_START = 2'b01,
        DMC_TX_DATA = 2'b10,
        DMC_TX_STOP = 2'b11
    } dmc_tx_e;

    typedef enum logic [1:0]
    {
        DMC_CMD_IDLE = 2'b00,
        DMC_CMD_CTRL = 2'b01,
        DMC_CMD_CNT_HI = 2'b10,
        DMC_CMD_CNT_LO = 2'b11
    } dmc_cmd_e;

endpackage

// ---- rtl/dmc_char_if.sv ----
// Character-level handshake between the link framer and the debug command logic.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface dmc_char_if;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_frame_err;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;

    modport framer
    (
        output rx_data,
        output rx_valid,
        output rx_frame_err,
        input tx_data,
        input tx_valid,
        output tx_ready
    );

    modport core
    (
        input rx_data,
        input rx_valid,
        input rx_frame_err,
        output tx_data,
        output tx_valid,
        input tx_ready
    );
endinterface
`default_nettype wire

// ---- rtl/dmc_link_framer.sv ----
// Half-duplex 8N1 character framer for the single-wire debug link.
// Assumes link_level is already synchronised and filtered on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module dmc_link_framer
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic link_level,
    output logic link_drive_low,
    dmc_char_if.framer chr
);
    dmc_pkg::dmc_rx_e rx_state;
    dmc_pkg::dmc_tx_e tx_state;
    logic [11:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [11:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic link_prev;
    logic rx_tick;
    logic tx_tick;

    assign rx_tick = (rx_cnt == 12'h000);
    assign tx_tick = (tx_cnt == dmc_pkg::BIT_LAST);
    assign chr.tx_ready = (tx_state == dmc_pkg::DMC_TX_IDLE);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            link_prev <= 1'b1;
        else
            link_prev <= link_level;
    end

    // Receiver is muted while transmitting so it never decodes its own echo
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state <= dmc_pkg::DMC_RX_IDLE;
            rx_cnt <= 12'h000;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            chr.rx_data <= 8'h00;
            chr.rx_valid <= 1'b0;
            chr.rx_frame_err <= 1'b0;
        end
        else
        begin
            chr.rx_valid <= 1'b0;
            chr.rx_frame_err <= 1'b0;
            if (!rx_tick)
                rx_cnt <= rx_cnt - 12'h001;
            unique case (rx_state)
                dmc_pkg::DMC_RX_IDLE:
                begin
                    if (link_prev && !link_level && chr.tx_ready)
                    begin
                        rx_state <= dmc_pkg::DMC_RX_START;
                        rx_cnt <= dmc_pkg::HALF_LAST;
                    end
                end
                dmc_pkg::DMC_RX_START:
                begin
                    if (rx_tick)
                    begin
                        // A start bit gone high at mid-bit was a glitch
                        rx_state <= link_level ? dmc_pkg::DMC_RX_IDLE : dmc_pkg::DMC_RX_DATA;
                        rx_cnt <= dmc_pkg::BIT_LAST;
                        rx_bit <= 3'h0;
                    end
                end
                dmc_pkg::DMC_RX_DATA:
                begin
                    if (rx_tick)
                    begin
                        rx_shift <= {link_level, rx_shift[7:1]};
                        rx_cnt <= dmc_pkg::BIT_LAST;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == dmc_pkg::DATA_LAST)
                            rx_state <= dmc_pkg::DMC_RX_STOP;
                    end
                end
                dmc_pkg::DMC_RX_STOP:
                begin
                    if (rx_tick)
                    begin
                        rx_state <= dmc_pkg::DMC_RX_IDLE;
                        chr.rx_data <= rx_shift;
                        chr.rx_valid <= link_level;
                        chr.rx_frame_err <= !link_level;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state <= dmc_pkg::DMC_TX_IDLE;
            tx_cnt <= 12'h000;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            link_drive_low <= 1'b0;
        end
        else
        begin
            tx_cnt <= tx_tick ? 12'h000 : tx_cnt + 12'h001;
            unique case (tx_state)
                dmc_pkg::DMC_TX_IDLE:
                begin
                    tx_cnt <= 12'h000;
                    if (chr.tx_valid)
                    begin
                        tx_shift <= chr.tx_data;
                        tx_state <= dmc_pkg::DMC_TX_START;
                        link_drive_low <= 1'b1;
                    end
                end
                dmc_pkg::DMC_TX_START:
                begin
                    if (tx_tick)
                    begin
                        tx_state <= dmc_pkg::DMC_TX_DATA;
                        tx_bit <= 3'h0;
                        link_drive_low <= !tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                    end
                end
                dmc_pkg::DMC_TX_DATA:
                begin
                    if (tx_tick)
                    begin
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == dmc_pkg::DATA_LAST)
                        begin
                            tx_state <= dmc_pkg::DMC_TX_STOP;
                            link_drive_low <= 1'b0;
                        end
                        else
                        begin
                            link_drive_low <= !tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                        end
                    end
                end
                dmc_pkg::DMC_TX_STOP:
                begin
                    if (tx_tick)
                        tx_state <= dmc_pkg::DMC_TX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dmc_debug_mode_control.sv ----
// Debug state entry and exit control with its single-wire host command link.
// Assumes rst_n combines power-on, brownout and reset-pin resets, and CPU-side
// inputs are synchronous to clk_sys; the link pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module dmc_debug_mode_control
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic debug_link_pin_in,
    output logic debug_link_pin_out,
    output logic debug_link_pin_oe,
    input wire logic breakpoint_opcode,
    input wire logic [15:0] pc_value,
    input wire logic instr_done,
    input wire logic debug_exec_req,
    input wire logic stop_mode,
    input wire logic wdt_enable,
    output logic debug_state,
    output logic cpu_fetch_halt,
    output logic sys_clock_run,
    output logic periph_run,
    output logic halt_exit,
    output logic wdt_refresh,
    output logic system_reset_req,
    output logic [15:0] debug_countdown_register,
    output logic [7:0] debug_control
);
    dmc_char_if chr();

    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic link_level;
    logic link_level_d;
    logic link_drive_low;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_enter;
    logic pc_match_en;
    logic countdown_en;
    logic pc_hit;
    logic cnt_step;
    logic cnt_hit;
    logic enter_event;
    logic host_ctrl_wr;
    logic [7:0] host_wdata;
    logic host_cnt_wr;
    logic [7:0] cnt_hi;
    logic debug_state_d;
    logic [7:0] reply_data;
    logic reply_valid;
    dmc_pkg::dmc_cmd_e cmd_state;

    dmc_link_framer u_framer
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .link_level(link_level),
        .link_drive_low(link_drive_low),
        .chr(chr.framer)
    );

    // Open-drain: only a low is ever driven
    assign debug_link_pin_out = 1'b0;
    assign debug_link_pin_oe = link_drive_low;
    assign chr.tx_data = reply_data;
    assign chr.tx_valid = reply_valid;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            link_level <= 1'b1;
            link_level_d <= 1'b1;
        end
        else
        begin
            pin_s1 <= debug_link_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3)
                link_level <= pin_s2;
            link_level_d <= link_level;
        end
    end

    // The pin is only trusted once the synchroniser has refilled after reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            strap_enter <= 1'b0;
        end
        else
        begin
            strap_enter <= 1'b0;
            if (strap_cnt != dmc_pkg::STRAP_WAIT)
                strap_cnt <= strap_cnt + 2'h1;
            else if (!strap_done)
            begin
                // Third stage holds its reset value until now, so sample only once both agree
                strap_done <= 1'b1;
                strap_enter <= !pin_s2 && !pin_s3;
            end
        end
    end

    // Host command decoding
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_state <= dmc_pkg::DMC_CMD_IDLE;
            host_ctrl_wr <= 1'b0;
            host_cnt_wr <= 1'b0;
            host_wdata <= 8'h00;
            cnt_hi <= 8'h00;
        end
        else
        begin
            host_ctrl_wr <= 1'b0;
            host_cnt_wr <= 1'b0;
            if (chr.rx_frame_err)
                cmd_state <= dmc_pkg::DMC_CMD_IDLE;
            else if (chr.rx_valid)
            begin
                unique case (cmd_state)
                    dmc_pkg::DMC_CMD_IDLE:
                    begin
                        if (chr.rx_data == dmc_pkg::CMD_WR_CTRL)
                            cmd_state <= dmc_pkg::DMC_CMD_CTRL;
                        else if (chr.rx_data == dmc_pkg::CMD_WR_CNT)
                            cmd_state <= dmc_pkg::DMC_CMD_CNT_HI;
                    end
                    dmc_pkg::DMC_CMD_CTRL:
                    begin
                        host_wdata <= chr.rx_data;
                        host_ctrl_wr <= 1'b1;
                        cmd_state <= dmc_pkg::DMC_CMD_IDLE;
                    end
                    dmc_pkg::DMC_CMD_CNT_HI:
                    begin
                        cnt_hi <= chr.rx_data;
                        cmd_state <= dmc_pkg::DMC_CMD_CNT_LO;
                    end
                    dmc_pkg::DMC_CMD_CNT_LO:
                    begin
                        host_wdata <= chr.rx_data;
                        host_cnt_wr <= 1'b1;
                        cmd_state <= dmc_pkg::DMC_CMD_IDLE;
                    end
                endcase
            end
        end
    end

    // Read-back of the control byte; a read arriving while one is pending is dropped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reply_valid <= 1'b0;
            reply_data <= 8'h00;
        end
        else if (reply_valid && chr.tx_ready)
            reply_valid <= 1'b0;
        else if (!reply_valid && chr.rx_valid && cmd_state == dmc_pkg::DMC_CMD_IDLE
                 && chr.rx_data == dmc_pkg::CMD_RD_CTRL)
        begin
            reply_valid <= 1'b1;
            reply_data <= debug_control;
        end
    end

    assign pc_hit = pc_match_en && !debug_state && (pc_value == debug_countdown_register);
    assign cnt_step = countdown_en && !debug_state && instr_done
                      && (debug_countdown_register != dmc_pkg::CNT_ZERO);
    assign cnt_hit = cnt_step && (debug_countdown_register == dmc_pkg::CNT_ONE);
    assign enter_event = breakpoint_opcode || pc_hit || cnt_hit || strap_enter;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            debug_countdown_register <= dmc_pkg::CNT_RESET;
        else if (host_cnt_wr)
            debug_countdown_register <= {cnt_hi, host_wdata};
        else if (cnt_step)
            debug_countdown_register <= debug_countdown_register - dmc_pkg::CNT_ONE;
    end

    // Reset clears the state bit and both entry enables
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debug_state <= dmc_pkg::CTRL_RESET[dmc_pkg::CTRL_DBG_BIT];
            pc_match_en <= dmc_pkg::CTRL_RESET[dmc_pkg::CTRL_PCM_EN_BIT];
            countdown_en <= dmc_pkg::CTRL_RESET[dmc_pkg::CTRL_CNT_EN_BIT];
        end
        else
        begin
            // A hardware entry in the same cycle as a host clear wins
            if (enter_event)
                debug_state <= 1'b1;
            else if (host_ctrl_wr)
                debug_state <= host_wdata[dmc_pkg::CTRL_DBG_BIT];
            if (host_ctrl_wr)
            begin
                pc_match_en <= host_wdata[dmc_pkg::CTRL_PCM_EN_BIT];
                countdown_en <= host_wdata[dmc_pkg::CTRL_CNT_EN_BIT];
            end
        end
    end

    always_comb
    begin
        debug_control = 8'h00;
        debug_control[dmc_pkg::CTRL_DBG_BIT] = debug_state;
        debug_control[dmc_pkg::CTRL_PCM_EN_BIT] = pc_match_en;
        debug_control[dmc_pkg::CTRL_CNT_EN_BIT] = countdown_en;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debug_state_d <= 1'b0;
            halt_exit <= 1'b0;
            wdt_refresh <= 1'b0;
            system_reset_req <= 1'b0;
        end
        else
        begin
            debug_state_d <= debug_state;
            halt_exit <= debug_state && !debug_state_d;
            wdt_refresh <= debug_state && wdt_enable;
            system_reset_req <= stop_mode && link_level_d && !link_level;
        end
    end

    assign cpu_fetch_halt = debug_state && !debug_exec_req;
    assign sys_clock_run = !stop_mode;
    assign periph_run = !stop_mode;
endmodule
`default_nettype wire

// ---- sim/dmc_props.sv ----
// Concurrent checks on the debug mode control top-level ports.
// Assumes one clk_sys domain with rst_n as its only reset.
`timescale 1ns/1ps
`default_nettype none
module dmc_props
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic debug_link_pin_in,
    input wire logic breakpoint_opcode,
    input wire logic [15:0] pc_value,
    input wire logic instr_done,
    input wire logic debug_exec_req,
    input wire logic stop_mode,
    input wire logic wdt_enable,
    input wire logic debug_state,
    input wire logic cpu_fetch_halt,
    input wire logic sys_clock_run,
    input wire logic periph_run,
    input wire logic halt_exit,
    input wire logic wdt_refresh,
    input wire logic system_reset_req,
    input wire logic [15:0] debug_countdown_register,
    input wire logic [7:0] debug_control
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_fetch_halt_gate: assert property (cpu_fetch_halt == (debug_state && !debug_exec_req))
        else $error("fetch halt wrong");
    a_clock_run_stop: assert property (sys_clock_run == !stop_mode)
        else $error("clock run wrong");
    a_periph_run_stop: assert property (periph_run == !stop_mode)
        else $error("peripheral run wrong");
    a_halt_exit_entry: assert property ($rose(debug_state) |=> halt_exit)
        else $error("no halt exit after entry");
    a_wdt_refresh_follow: assert property (wdt_refresh == $past(debug_state && wdt_enable))
        else $error("watchdog refresh wrong");
    a_ctrl_state_mirror: assert property (debug_control[7] == debug_state)
        else $error("control bit differs from state");
    a_break_enters: assert property (breakpoint_opcode && !debug_state |=> debug_state)
        else $error("breakpoint did not enter");
    a_pc_match_enters: assert property (
        debug_control[1] && !debug_state && pc_value == debug_countdown_register |=> debug_state)
        else $error("pc match did not enter");
    a_count_zero_enters: assert property (debug_control[0] && !debug_state && instr_done
        && debug_countdown_register == dmc_pkg::CNT_ONE |=> debug_state)
        else $error("countdown did not enter");
    a_strap_entry: assert property (($rose(rst_n) && !debug_link_pin_in)
        ##1 (!debug_link_pin_in) [*3] |-> ##[1:3] debug_state)
        else $error("pin strap did not enter");
    a_reset_clears: assert property ($rose(rst_n) |-> debug_control == 8'h00
        && debug_countdown_register == 16'h0000)
        else $error("reset left state behind");
    a_stop_pin_reset: assert property (stop_mode && $fell(debug_link_pin_in)
        |-> ##[1:8] system_reset_req)
        else $error("no reset request in stop");

    c_break_entry: cover property (breakpoint_opcode && !debug_state);
    c_pc_entry: cover property (debug_control[1] && $rose(debug_state));
    c_stop_reset: cover property (system_reset_req);
endmodule

bind dmc_debug_mode_control dmc_props u_props
(
    .clk_sys(clk_sys), .rst_n(rst_n), .debug_link_pin_in(debug_link_pin_in),
    .breakpoint_opcode(breakpoint_opcode), .pc_value(pc_value), .instr_done(instr_done),
    .debug_exec_req(debug_exec_req), .stop_mode(stop_mode), .wdt_enable(wdt_enable),
    .debug_state(debug_state), .cpu_fetch_halt(cpu_fetch_halt),
    .sys_clock_run(sys_clock_run), .periph_run(periph_run), .halt_exit(halt_exit),
    .wdt_refresh(wdt_refresh), .system_reset_req(system_reset_req),
    .debug_countdown_register(debug_countdown_register), .debug_control(debug_control)
);
`default_nettype wire

// ---- sim/dmc_host_model.sv ----
// Behavioural debug host that pulls the link wire low to send 8N1 characters.
// Assumes the bench resolves the pulled-up wire from this pull-down and the device enable.
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model
#(
    parameter int unsigned BIT_CYCLES = dmc_pkg::BIT_CYCLES
)
(
    input wire logic clk_sys,
    output logic host_low
);
    initial
        host_low = 1'b0;

    // Released wire returns to the pull-up, so idle needs no drive
    task automatic hold_low(input logic low);
        @(posedge clk_sys);
        host_low <= low;
    endtask

    // Start low, data LSB first, stop high; idle gap bits model a slow host
    task automatic send_char(input logic [7:0] value, input int gap_bits);
        logic [9:0] frame;
        frame = {1'b1, value, 1'b0};
        for (int i = 0; i < 10 + gap_bits; i++)
        begin
            @(posedge clk_sys);
            host_low <= (i < 10) ? !frame[i] : 1'b0;
            repeat (BIT_CYCLES - 1) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for debug state entry, exit and link framing.
// Assumes the host model on a pulled-up link wire and a 200 MHz clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys;
    logic rst_n;
    logic host_low;
    wire logic link_wire;
    logic pin_out, pin_oe, bp, instr_done, exec_req, stop_mode, wdt_en;
    logic [15:0] pc_value;
    logic dstate, fetch_halt, clk_run, per_run, halt_exit, wdt_ref, rst_req;
    logic [15:0] counter;
    logic [7:0] ctrl;
    int fails = 0;
    int checks_done = 0;

    // Open-drain wire: low when either party pulls
    assign link_wire = !(host_low || (pin_oe && !pin_out));

    dmc_debug_mode_control DUT
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .debug_link_pin_in(link_wire),
        .debug_link_pin_out(pin_out), .debug_link_pin_oe(pin_oe), .breakpoint_opcode(bp),
        .pc_value(pc_value), .instr_done(instr_done), .debug_exec_req(exec_req),
        .stop_mode(stop_mode), .wdt_enable(wdt_en), .debug_state(dstate),
        .cpu_fetch_halt(fetch_halt), .sys_clock_run(clk_run), .periph_run(per_run),
        .halt_exit(halt_exit), .wdt_refresh(wdt_ref), .system_reset_req(rst_req),
        .debug_countdown_register(counter), .debug_control(ctrl)
    );

    dmc_host_model HOST
    (
        .clk_sys(clk_sys),
        .host_low(host_low)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_strap();
        int n;
        n = 0;
        while (dstate !== 1'b1 && n < 10)
        begin
            tick(1);
            n++;
        end
        check("strap entry", {15'h0, dstate}, 16'h0001);
        tick(1);
        check("halt exit", {15'h0, halt_exit}, 16'h0001);
        check("wdt refresh on", {15'h0, wdt_ref}, 16'h0001);
        check("fetch halted", {15'h0, fetch_halt}, 16'h0001);
        check("control", {8'h00, ctrl}, 16'h0080);
        @(posedge clk_sys);
        exec_req <= 1'b1;
        wdt_en <= 1'b0;
        tick(1);
        check("directed fetch", {15'h0, fetch_halt}, 16'h0000);
        check("wdt refresh off", {15'h0, wdt_ref}, 16'h0000);
        @(posedge clk_sys);
        exec_req <= 1'b0;
        wdt_en <= 1'b1;
        // Releasing the pin aborts the start the strap looked like
        HOST.hold_low(1'b0);
        tick(1000);
    endtask

    task automatic t_host_ctrl(input logic [7:0] value);
        HOST.send_char(dmc_pkg::CMD_WR_CTRL, 0);
        HOST.send_char(value, 0);
        tick(1);
        check("control write", {8'h00, ctrl}, {8'h00, value & 8'h83});
        check("fetch after write", {15'h0, fetch_halt}, {15'h0, value[7]});
    endtask

    task automatic t_pc_match();
        @(posedge clk_sys);
        pc_value <= dmc_pkg::CNT_RESET;
        tick(1);
        check("pc match entry", {15'h0, dstate}, 16'h0001);
        @(posedge clk_sys);
        pc_value <= 16'h1234;
    endtask

    task automatic t_stop();
        int n;
        n = 0;
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        tick(1);
        check("clock stopped", {15'h0, clk_run}, 16'h0000);
        check("periph stopped", {15'h0, per_run}, 16'h0000);
        HOST.hold_low(1'b1);
        repeat (12)
        begin
            tick(1);
            if (rst_req === 1'b1)
                n++;
        end
        check("reset request", n[15:0], 16'h0001);
        HOST.hold_low(1'b0);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        tick(1000);
        check("clock running", {15'h0, clk_run}, 16'h0001);
        check("debug kept", {15'h0, dstate}, 16'h0001);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tick(2);
        check("state in reset", {15'h0, dstate}, 16'h0000);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(4);
        check("control reset", {8'h00, ctrl}, {8'h00, dmc_pkg::CTRL_RESET});
        check("counter reset", counter, dmc_pkg::CNT_RESET);
    endtask

    // Host asks for the control byte and decodes the reply off the wire near mid-bit
    task automatic t_readback(input logic [7:0] value);
        logic [7:0] got;
        got = 8'h00;
        HOST.send_char(dmc_pkg::CMD_RD_CTRL, 0);
        tick(0);
        check("reply start", {15'h0, link_wire}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            tick(dmc_pkg::BIT_CYCLES);
            got[i] = link_wire;
        end
        check("reply data", {8'h00, got}, {8'h00, value & 8'h83});
        tick(dmc_pkg::BIT_CYCLES);
        check("reply stop", {15'h0, link_wire}, 16'h0001);
    endtask

    task automatic t_breakpoint();
        @(posedge clk_sys);
        bp <= 1'b1;
        @(posedge clk_sys);
        bp <= 1'b0;
        #1;
        check("breakpoint entry", {15'h0, dstate}, 16'h0001);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        // Five host characters and one reply dominate, about 105k cycles in all
        #600000;
        fails++;
        give_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        bp = 1'b0;
        pc_value = 16'h1234;
        instr_done = 1'b0;
        exec_req = 1'b0;
        stop_mode = 1'b0;
        wdt_en = 1'b1;
        HOST.hold_low(1'b1);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_strap();
        t_host_ctrl(8'h03);
        t_pc_match();
        t_stop();
        do_reset();
        t_breakpoint();
        do_reset();
        t_host_ctrl(8'h80);
        t_readback(8'h80);
        give_verdict();
    end
endmodule
`default_nettype wire
